// file: common/dbm_pkg.sv
// Purpose: Shared constants and types for the DRAM burst option and address mux block.
// Assumes: A 16-bit control register in the low half of a 32-bit Avalon-MM word.
// Notes:   Offsets, field positions, the control reset value and the row shift base are defined here.

package dbm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned DBM_AVM_ADDR_W = 4;
    localparam logic [3:0] DBM_OFS_CTRL = 4'h0;
    localparam logic [3:0] DBM_OFS_STAT = 4'h4;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam logic [15:0] DBM_CTRL_RESET = 16'h0000;
    // Bits 7, 5, 4, 3 and 2..0 are stored; every other bit reads as zero.
    localparam logic [15:0] DBM_CTRL_WMASK = 16'h00BF;
    localparam int unsigned DBM_BIT_BE = 7;
    localparam int unsigned DBM_BIT_DDS = 5;
    localparam int unsigned DBM_BIT_EXT_DMA_SINGLE_BURST_OPTION = 4;
    localparam int unsigned DBM_BIT_RSVD = 3;
    localparam int unsigned DBM_BIT_MUX_HI = 2;
    localparam int unsigned DBM_BIT_MUX_LO = 0;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int unsigned DBM_STAT_BURST = 0;
    localparam int unsigned DBM_STAT_HIT = 1;
    localparam int unsigned DBM_STAT_OPEN = 2;

    // ----------------------------------------------------------------
    // Address multiplexing
    // ----------------------------------------------------------------
    localparam int unsigned DBM_ADDR_W = 24;
    localparam int unsigned DBM_COL_W = 16;
    localparam logic [4:0] DBM_ROW_SHIFT_BASE = 5'h08;
    localparam logic DBM_PRECHARGE_FILL = 1'b1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DBM_MST_CPU = 2'h0,
        DBM_MST_ONCHIP_DMA = 2'h1,
        DBM_MST_EXT_DMA = 2'h2,
        DBM_MST_OTHER = 2'h3
    } dbm_master_e;

    typedef enum logic [1:0] {
        DBM_ST_IDLE = 2'b01,
        DBM_ST_ACK = 2'b10
    } dbm_bus_e;

endpackage

// file: rtl/dbm_addr_mux.sv
// Purpose: Row/column split, page compare mask and precharge marking of a DRAM address.
// Assumes: Purely combinational; the caller registers row, column and precharge and uses the compare mask unregistered.
// Notes:   The shift is eight plus the two low select bits for every select code.

`timescale 1ns/1ps
`default_nettype none

module dbm_addr_mux
    import dbm_pkg::*;
(
    input wire logic [DBM_ADDR_W-1:0] addr_in,
    input wire logic [2:0] shift_sel_in,
    input wire logic wide16_in,
    input wire logic sdram_cont_in,
    output logic [DBM_ADDR_W-1:0] row_addr_out,
    output logic [DBM_COL_W-1:0] col_addr_out,
    output logic [DBM_ADDR_W-1:0] cmp_mask_out,
    output logic precharge_sel_out
);

    logic [4:0] shift;
    logic [4:0] cmp_lsb;

    always_comb begin
        shift = DBM_ROW_SHIFT_BASE + {3'h0, shift_sel_in[1:0]};
        // A 16-bit space drops one more low bit from the compare.
        cmp_lsb = shift + {4'h0, wide16_in};
        row_addr_out = addr_in >> shift;
        cmp_mask_out = {DBM_ADDR_W{1'b1}} << cmp_lsb;
        precharge_sel_out = sdram_cont_in & shift_sel_in[2];
    end

    // ----------------------------------------------------------------
    // Column bits: address below the shift, precharge mark above it
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DBM_COL_W; i++) begin : g_col
            assign col_addr_out[i] = (5'(i) < shift) ? addr_in[i] :
                (precharge_sel_out ? DBM_PRECHARGE_FILL : 1'b0);
        end
    endgenerate

endmodule

`default_nettype wire

// file: rtl/dbm_burst_decide.sv
// Purpose: Decide whether one DRAM access may run as a fast page burst.
// Assumes: Master identity and single/dual flag come from the bus arbiter.
// Notes:   Combinational; the caller samples it at access start.

`timescale 1ns/1ps
`default_nettype none

module dbm_burst_decide
    import dbm_pkg::*;
(
    input wire logic burst_access_enable_in,
    input wire logic onchip_dma_single_burst_option_in,
    input wire logic ext_dma_single_burst_option_in,
    input wire logic dram_in,
    input wire logic single_in,
    input wire dbm_master_e master_in,
    output logic burst_ok_out
);

    always_comb begin
        // Burst enable off forces full access for every master.
        burst_ok_out = burst_access_enable_in & dram_in;
        if (single_in && master_in == DBM_MST_ONCHIP_DMA) begin
            burst_ok_out = burst_ok_out & onchip_dma_single_burst_option_in;
        end else if (single_in && master_in == DBM_MST_EXT_DMA) begin
            burst_ok_out = burst_ok_out & ext_dma_single_burst_option_in;
        end
        // Dual-address transfers and other masters see only the enable and the DRAM space flag.
    end

endmodule

`default_nettype wire

// file: rtl/dbm_top.sv
// Purpose: DRAM interface control register with burst options and address multiplexing.
// Assumes: Access requests come from logic on the same clock as one-cycle start pulses.
// Notes:   Results of an access appear one cycle after its start pulse.

`timescale 1ns/1ps
`default_nettype none

module dbm_top
    import dbm_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [DBM_AVM_ADDR_W-1:0] avm_address_in,
    input wire logic avm_read_in,
    input wire logic avm_write_in,
    input wire logic [31:0] avm_writedata_in,
    input wire logic [3:0] avm_byteenable_in,
    output logic [31:0] avm_readdata_out,
    output logic avm_waitrequest_out,
    input wire logic acc_start_in,
    input wire logic [DBM_ADDR_W-1:0] acc_addr_in,
    input wire dbm_master_e acc_master_in,
    input wire logic acc_single_in,
    input wire logic acc_dram_in,
    input wire logic acc_wide16_in,
    input wire logic acc_sdram_cont_in,
    output logic acc_valid_out,
    output logic acc_burst_out,
    output logic acc_page_hit_out,
    output logic [DBM_ADDR_W-1:0] row_addr_out,
    output logic [DBM_COL_W-1:0] col_addr_out,
    output logic precharge_sel_out,
    output logic burst_access_enable_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        dbm_bus_e st;
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0] ctrl;
        logic acc_valid;
        logic burst;
        logic hit;
        logic [DBM_ADDR_W-1:0] row;
        logic [DBM_COL_W-1:0] col;
        logic prech;
        logic [DBM_ADDR_W-1:0] open_row;
        logic open_valid;
    } dbm_top_s;

    localparam dbm_top_s DBM_TOP_RESET = '{
        st: DBM_ST_IDLE,
        waitreq: 1'b1,
        rdata: 32'h0000_0000,
        ctrl: DBM_CTRL_RESET,
        acc_valid: 1'b0,
        burst: 1'b0,
        hit: 1'b0,
        row: 24'h00_0000,
        col: 16'h0000,
        prech: 1'b0,
        open_row: 24'h00_0000,
        open_valid: 1'b0
    };

    dbm_top_s s;
    dbm_top_s next_s;

    logic burst_ok;
    logic [DBM_ADDR_W-1:0] mux_row;
    logic [DBM_COL_W-1:0] mux_col;
    logic [DBM_ADDR_W-1:0] cmp_mask;
    logic mux_prech;
    logic [31:0] rd_word;
    logic cfg_drop;

    // ----------------------------------------------------------------
    // Access decision and address split
    // ----------------------------------------------------------------
    // Both helpers read the stored register, so a write finishing at the
    // same edge as an access start is seen only by the following access.
    dbm_burst_decide u_decide (
        .burst_access_enable_in(s.ctrl[DBM_BIT_BE]),
        .onchip_dma_single_burst_option_in(s.ctrl[DBM_BIT_DDS]),
        .ext_dma_single_burst_option_in(s.ctrl[DBM_BIT_EXT_DMA_SINGLE_BURST_OPTION]),
        .dram_in(acc_dram_in),
        .single_in(acc_single_in),
        .master_in(acc_master_in),
        .burst_ok_out(burst_ok)
    );

    dbm_addr_mux u_mux (
        .addr_in(acc_addr_in),
        .shift_sel_in(s.ctrl[DBM_BIT_MUX_HI:DBM_BIT_MUX_LO]),
        .wide16_in(acc_wide16_in),
        .sdram_cont_in(acc_sdram_cont_in),
        .row_addr_out(mux_row),
        .col_addr_out(mux_col),
        .cmp_mask_out(cmp_mask),
        .precharge_sel_out(mux_prech)
    );

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    always_comb begin
        case (avm_address_in)
            DBM_OFS_CTRL: begin
                rd_word = {16'h0000, s.ctrl};
            end
            DBM_OFS_STAT: begin
                rd_word = 32'h0000_0000;
                rd_word[DBM_STAT_BURST] = s.burst;
                rd_word[DBM_STAT_HIT] = s.hit;
                rd_word[DBM_STAT_OPEN] = s.open_valid;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.acc_valid = 1'b0;
        case (s.st)
            DBM_ST_IDLE: begin
                next_s.waitreq = 1'b1;
                if (avm_read_in || avm_write_in) begin
                    next_s.st = DBM_ST_ACK;
                    next_s.waitreq = 1'b0;
                    next_s.rdata = rd_word;
                end
            end
            DBM_ST_ACK: begin
                // The write lands at the edge where the master sees waitrequest low.
                next_s.st = DBM_ST_IDLE;
                next_s.waitreq = 1'b1;
                if (avm_write_in && avm_address_in == DBM_OFS_CTRL) begin
                    if (avm_byteenable_in[0]) begin
                        next_s.ctrl[7:0] = avm_writedata_in[7:0] & DBM_CTRL_WMASK[7:0];
                    end
                    if (avm_byteenable_in[1]) begin
                        next_s.ctrl[15:8] = avm_writedata_in[15:8] & DBM_CTRL_WMASK[15:8];
                    end
                end
            end
            default: begin
                next_s.st = DBM_ST_IDLE;
                next_s.waitreq = 1'b1;
            end
        endcase

        // An open page is forgotten once burst is disabled or any of the select bits 2..0 changes.
        cfg_drop = !next_s.ctrl[DBM_BIT_BE] ||
            (next_s.ctrl[DBM_BIT_MUX_HI:DBM_BIT_MUX_LO] !=
             s.ctrl[DBM_BIT_MUX_HI:DBM_BIT_MUX_LO]);
        if (cfg_drop) begin
            next_s.open_valid = 1'b0;
        end

        // An access start in the same cycle wins over the drop above.
        if (acc_start_in) begin
            next_s.acc_valid = 1'b1;
            next_s.burst = burst_ok;
            next_s.hit = burst_ok && s.open_valid &&
                (((acc_addr_in ^ s.open_row) & cmp_mask) == 24'h00_0000);
            next_s.row = mux_row;
            next_s.col = mux_col;
            next_s.prech = mux_prech;
            next_s.open_row = acc_addr_in;
            next_s.open_valid = burst_ok;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= DBM_TOP_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avm_readdata_out = s.rdata;
    assign avm_waitrequest_out = s.waitreq;
    assign acc_valid_out = s.acc_valid;
    assign acc_burst_out = s.burst;
    assign acc_page_hit_out = s.hit;
    assign row_addr_out = s.row;
    assign col_addr_out = s.col;
    assign precharge_sel_out = s.prech;
    assign burst_access_enable_out = s.ctrl[DBM_BIT_BE];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dbm_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    onchip_full_a: assert property (
        acc_start_in && acc_single_in && acc_master_in == DBM_MST_ONCHIP_DMA &&
        !s.ctrl[DBM_BIT_DDS] |=> acc_valid_out && !acc_burst_out)
        else $error("On-chip DMA single transfer burst while option is off.");

    be_off_full_a: assert property (
        acc_start_in && !s.ctrl[DBM_BIT_BE] |=> !acc_burst_out && !acc_page_hit_out)
        else $error("Burst granted while burst enable is off.");

    other_master_a: assert property (
        acc_start_in && acc_dram_in && s.ctrl[DBM_BIT_BE] &&
        (!acc_single_in || acc_master_in == DBM_MST_CPU ||
         acc_master_in == DBM_MST_OTHER) |=> acc_burst_out)
        else $error("Burst denied to a master the DMA options do not govern.");

    ext_full_a: assert property (
        acc_start_in && acc_single_in && acc_master_in == DBM_MST_EXT_DMA &&
        !s.ctrl[DBM_BIT_EXT_DMA_SINGLE_BURST_OPTION] |=> acc_valid_out && !acc_burst_out)
        else $error("External DMA single transfer burst while option is off.");

    ext_dual_a: assert property (
        acc_start_in && acc_dram_in && s.ctrl[DBM_BIT_BE] && !acc_single_in &&
        acc_master_in == DBM_MST_EXT_DMA |=> acc_burst_out)
        else $error("External DMA dual transfer affected by its single option.");

    rsvd_bit_a: assert property (
        s.st == DBM_ST_ACK && avm_write_in && avm_address_in == DBM_OFS_CTRL &&
        avm_byteenable_in[0] |=> s.ctrl[DBM_BIT_RSVD] == $past(avm_writedata_in[3]))
        else $error("Reserved bit did not store the written value.");

    row_shift_a: assert property (
        acc_start_in |=> row_addr_out == ($past(acc_addr_in) >>
            (DBM_ROW_SHIFT_BASE + {3'h0, $past(s.ctrl[1:0])})))
        else $error("Row address shifted by the wrong amount.");

    hit_burst_a: assert property (
        acc_valid_out && acc_page_hit_out |-> acc_burst_out && $past(s.open_valid))
        else $error("Page hit reported without burst or open page.");

    precharge_a: assert property (
        acc_start_in |=> precharge_sel_out ==
            ($past(acc_sdram_cont_in) && $past(s.ctrl[DBM_BIT_MUX_HI])))
        else $error("Precharge marking disagrees with space and select.");

    bus_answer_a: assert property (
        s.st == DBM_ST_IDLE && (avm_read_in || avm_write_in) |=>
            !avm_waitrequest_out ##1 avm_waitrequest_out)
        else $error("Register access not answered in exactly one wait cycle.");

    ext_be_off_a: assert property (
        acc_start_in && acc_single_in && acc_master_in == DBM_MST_EXT_DMA &&
        !s.ctrl[DBM_BIT_BE] |=> !acc_burst_out && !acc_page_hit_out)
        else $error("External DMA single transfer burst while burst enable is off.");

    non_dram_a: assert property (
        acc_start_in && !acc_dram_in |=> acc_valid_out && !acc_burst_out)
        else $error("Access outside DRAM space granted a burst.");

    page_match_a: assert property (
        acc_start_in && acc_dram_in && s.ctrl[DBM_BIT_BE] && !acc_single_in &&
        s.open_valid && (((acc_addr_in ^ s.open_row) >> (DBM_ROW_SHIFT_BASE +
        {3'h0, s.ctrl[1:0]} + {4'h0, acc_wide16_in})) == 24'h00_0000) |=> acc_page_hit_out)
        else $error("Same row under an open page not reported as a hit.");

    col_fill_a: assert property (
        acc_start_in && acc_sdram_cont_in && s.ctrl[DBM_BIT_MUX_HI] |=>
            col_addr_out[DBM_COL_W-1])
        else $error("Top column bit not marked for precharge.");

    onchip_burst_c: cover property (
        acc_start_in && acc_single_in && acc_master_in == DBM_MST_ONCHIP_DMA ##1 acc_burst_out);
    page_hit_c: cover property (
        acc_valid_out && acc_page_hit_out);
    ext_burst_c: cover property (
        acc_start_in && acc_single_in && acc_master_in == DBM_MST_EXT_DMA ##1 acc_burst_out);
    ctrl_write_c: cover property (
        s.st == DBM_ST_ACK && avm_write_in && avm_address_in == DBM_OFS_CTRL);
    precharge_c: cover property (
        precharge_sel_out && acc_valid_out);

endmodule

`default_nettype wire

// file: testbench/dbm_dram_model.sv
// Purpose: Far-side DRAM stand-in that rebuilds the full address from the row and column.
// Assumes: Row and column are valid in the cycle of the access valid pulse.
// Notes:   Upper column bits may carry the precharge marking, so they are masked off here.

`timescale 1ns/1ps
`default_nettype none

module dbm_dram_model
    import dbm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [DBM_ADDR_W-1:0] row_in,
    input wire logic [DBM_COL_W-1:0] col_in,
    input wire logic [1:0] shift_lo_in,
    output logic [DBM_ADDR_W-1:0] addr_out,
    output logic [31:0] count_out
);
    // ----------------------------------------------------------------
    // Address rebuild, row above the shift and column below it
    // ----------------------------------------------------------------
    logic [4:0] shift;
    logic [DBM_ADDR_W-1:0] low_mask;

    always_comb begin
        shift = 5'(DBM_ROW_SHIFT_BASE) + {3'h0, shift_lo_in};
        low_mask = (24'h000001 << shift) - 24'h000001;
        addr_out = (row_in << shift) | ({8'h00, col_in} & low_mask);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= 32'h0;
        end else if (valid_in) begin
            count_out <= count_out + 32'h1;
        end
    end
endmodule

`default_nettype wire

// file: testbench/dram_burst_option_and_addr_mux_test.sv
// Purpose: Self-checking bench comparing the block with a behavioural model at every access.
// Assumes: Avalon answers whenever waitrequest falls; access results one cycle after start.
// Notes:   The bench never writes the control register in the cycle of an access start.

`timescale 1ns/1ps
`default_nettype none

module dram_burst_option_and_addr_mux_test;
    import dbm_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] av_addr = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [3:0] av_be = 4'hF;
    logic [31:0] av_rdata;
    logic av_wait;
    logic start = 1'b0;
    logic [23:0] a_addr = 24'h0;
    dbm_master_e a_mst = DBM_MST_CPU;
    logic a_single = 1'b0;
    logic a_dram = 1'b0;
    logic a_wide = 1'b0;
    logic a_sdc = 1'b0;
    logic v_out, b_out, h_out, p_out, be_out;
    logic [23:0] row_out, rebuilt;
    logic [15:0] col_out;
    logic [31:0] n_seen;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] lf = 32'd32;
    logic [15:0] m_ctrl = 16'h0;
    logic m_open = 1'b0;
    logic m_burst = 1'b0;
    logic m_hit = 1'b0;
    logic [23:0] m_row = 24'h0;

    always #10 clk = ~clk;

    dbm_top dut (.clk_sys_in(clk), .rst_in(rst), .avm_address_in(av_addr),
        .avm_read_in(av_rd), .avm_write_in(av_wr), .avm_writedata_in(av_wd),
        .avm_byteenable_in(av_be), .avm_readdata_out(av_rdata), .avm_waitrequest_out(av_wait),
        .acc_start_in(start), .acc_addr_in(a_addr), .acc_master_in(a_mst),
        .acc_single_in(a_single), .acc_dram_in(a_dram), .acc_wide16_in(a_wide),
        .acc_sdram_cont_in(a_sdc), .acc_valid_out(v_out), .acc_burst_out(b_out),
        .acc_page_hit_out(h_out), .row_addr_out(row_out), .col_addr_out(col_out),
        .precharge_sel_out(p_out), .burst_access_enable_out(be_out));

    dbm_dram_model far (.clk_in(clk), .rst_in(rst), .valid_in(v_out), .row_in(row_out),
        .col_in(col_out), .shift_lo_in(m_ctrl[1:0]), .addr_out(rebuilt), .count_out(n_seen));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The request stands until the edge at which waitrequest is seen low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] en, output logic [31:0] q);
        @(posedge clk);
        av_addr <= a;
        av_rd <= ~wr;
        av_wr <= wr;
        av_wd <= d;
        av_be <= en;
        @(posedge clk);
        while (av_wait !== 1'b0) begin
            @(posedge clk);
        end
        q = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d, input logic [3:0] en);
        logic [31:0] q;
        logic [15:0] nb;
        bus(1'b1, a, {16'h0, d}, en, q);
        nb = d & DBM_CTRL_WMASK;
        if (a == DBM_OFS_CTRL && en[0]) begin
            if (!nb[7] || nb[2:0] != m_ctrl[2:0]) m_open = 1'b0;
            m_ctrl = nb;
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(q, exp);
    endtask

    task automatic acc(input logic [1:0] m, input logic s, input logic d, input logic w,
            input logic c, input logic [23:0] a);
        int sh;
        logic bu, hi, pre;
        logic [23:0] mask;
        logic [15:0] ce;
        @(posedge clk);
        start <= 1'b1;
        a_mst <= dbm_master_e'(m);
        a_single <= s;
        a_dram <= d;
        a_wide <= w;
        a_sdc <= c;
        a_addr <= a;
        @(posedge clk);
        start <= 1'b0;
        sh = 8 + int'(m_ctrl[1:0]);
        bu = m_ctrl[7] && d && !(s && ((m == 2'h1 && !m_ctrl[5]) || (m == 2'h2 && !m_ctrl[4])));
        mask = ~((24'h000001 << (sh + int'(w))) - 24'h000001);
        hi = bu && m_open && (((a ^ m_row) & mask) == 24'h0);
        pre = c && m_ctrl[2];
        for (int k = 0; k < 16; k++) ce[k] = (k < sh) ? a[k] : pre;
        @(negedge clk);
        check(32'(v_out), 32'h1);
        if (!m_ctrl[7]) check(32'(b_out), 32'(bu));
        else if (s && m == 2'h1) check(32'(b_out), 32'(bu));
        else if (s && m == 2'h2) check(32'(b_out), 32'(bu));
        else check(32'(b_out), 32'(bu));
        check(32'(h_out), 32'(hi));
        check(32'(row_out), 32'(a >> sh));
        check(32'(col_out), 32'(ce));
        check(32'(rebuilt), 32'(a));
        check(32'(p_out), 32'(pre));
        check(32'(be_out), 32'(m_ctrl[7]));
        if (bu) m_row = a;
        m_open = bu;
        m_burst = bu;
        m_hit = hi;
        @(negedge clk);
        check(32'(v_out), 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        logic [23:0] na;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(DBM_OFS_CTRL, 32'h0);
        rd_chk(DBM_OFS_STAT, 32'h0);
        check(32'(be_out), 32'h0);
        wr_reg(DBM_OFS_CTRL, 16'hFFFF, 4'hF);
        rd_chk(DBM_OFS_CTRL, 32'h0000_00BF);
        wr_reg(DBM_OFS_CTRL, 16'h0000, 4'h2);
        rd_chk(DBM_OFS_CTRL, 32'h0000_00BF);
        wr_reg(DBM_OFS_CTRL, 16'h0008, 4'hF);
        rd_chk(DBM_OFS_CTRL, 32'h0000_0008);
        wr_reg(4'hC, 16'h00FF, 4'hF);
        wr_reg(DBM_OFS_STAT, 16'h00FF, 4'hF);
        rd_chk(4'h8, 32'h0);
        rd_chk(DBM_OFS_CTRL, 32'h0000_0008);
        // Every burst option and multiplex code, each against all masters and kinds.
        for (int i = 0; i < 64; i++) begin
            wr_reg(DBM_OFS_CTRL, {8'h00, i[5], 1'b0, i[4], i[3], 1'b0, i[2:0]}, 4'h3);
            rd_chk(DBM_OFS_CTRL, {16'h0, m_ctrl});
            for (int j = 0; j < 16; j++) begin
                lf = lfsr_next(lf);
                na = (lf[1:0] != 2'h0) ? {m_row[23:8], lf[9:2]} : lf[31:8];
                acc(j[1:0], j[2], j[3] | lf[12], lf[10], lf[11], na);
            end
            rd_chk(DBM_OFS_STAT, {29'h0, m_open, m_hit, m_burst});
        end
        check(n_seen, 32'h0000_0400);
        print_verdict();
    end
endmodule

`default_nettype wire
